// ### bench/fbd_asserts.sv
// checker for the flash sequencer: pin cycle shape and answers
// assumes it is bound to fbd_controller and sees only its ports
`timescale 1ns/10ps
module fbd_asserts
  import fbd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic rsp_valid,
  input wire logic rsp_err,
  input wire fbd_mode_e mode_state,
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic flash_dq_oe_n,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n,
  input wire logic accelerate_pin
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // write strobe five clocks, then four of recovery under select
  sequence s_write;
    !flash_we_n [*5] ##1 (flash_we_n && !flash_ce_n) [*4] ##1 flash_ce_n;
  endsequence
  // read window nine clocks, same recovery
  sequence s_read;
    !flash_oe_n [*8] ##1 !flash_oe_n ##1 (flash_oe_n && !flash_ce_n) [*4] ##1 flash_ce_n;
  endsequence
  a_write_cycle_shape: assert property ($fell(flash_we_n) |-> s_write)
    else $error("write cycle shape wrong");
  a_read_cycle_shape: assert property ($fell(flash_oe_n) |-> s_read)
    else $error("read cycle shape wrong");
  a_setup_before_strobe: assert property ($fell(flash_we_n) |->
    $past(flash_ce_n, 3) == 1'b0 && $past(flash_ce_n, 4) == 1'b1)
    else $error("address setup not three clocks");
  a_write_drives_bus: assert property (!flash_we_n |-> !flash_dq_oe_n && !flash_ce_n && flash_oe_n)
    else $error("write strobe without driven data");
  a_read_releases_bus: assert property (!flash_oe_n |-> flash_dq_oe_n && flash_we_n)
    else $error("read with data lines driven");
  a_addr_held_steady: assert property (!flash_ce_n && $past(flash_ce_n) == 1'b0 |-> $stable(flash_addr))
    else $error("address moved inside a cycle");
  a_refusal_quiet: assert property (rsp_err |-> rsp_valid && flash_ce_n && $past(flash_ce_n))
    else $error("refused op touched the pins");
  a_accel_in_guard: assert property (accelerate_pin |-> mode_state == MODE_PERS || mode_state == MODE_DYN)
    else $error("accelerate outside guard modes");
  a_mode_on_done: assert property ($changed(mode_state) |-> rsp_valid || $past(rsp_valid))
    else $error("mode moved without completion");
endmodule
bind fbd_controller fbd_asserts fbd_asserts_i (.clk_sys, .resetn, .rsp_valid, .rsp_err, .mode_state,
  .flash_addr, .flash_dq_oe_n, .flash_ce_n, .flash_we_n, .flash_oe_n, .accelerate_pin);

// ### bench/fbd_controller_tb.sv
// self-checking bench for the flash sequencer, one task per scenario
// assumes the flash model on the pins and the checker bound on its own
`timescale 1ns/10ps
module fbd_controller_tb
  import fbd_pkg::*;
;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic ce_sys = 1'b1; // clock enable, dropped in one scenario
  logic cmd_valid = 1'b0;
  fbd_op_e cmd_op = OP_READ;
  logic [22:0] cmd_addr = 23'h000000;
  logic [7:0] cmd_data = 8'h00;
  logic [63:0] cmd_secret = 64'h8877665544332211;
  logic cmd_ready, rsp_valid, rsp_err, rsp_unprotected, accelerate_pin;
  logic flash_dq_oe_n, flash_ce_n, flash_we_n, flash_oe_n;
  logic [7:0] rsp_data, flash_dq_o, flash_dq_i;
  logic [22:0] flash_addr;
  fbd_mode_e mode_state;
  logic [30:0] exq[$]; // expected write cycles
  logic got_err; // refusal flag seen with the answer
  logic accel_hi; // accelerate seen during the last op
  int err_count = 0;
  int num_checks = 0;
  int cycles = 0;
  always #4 clk_sys = ~clk_sys;
  fbd_controller fbd_controller_i (.clk_sys, .resetn, .ce_sys, .cmd_valid, .cmd_ready, .cmd_op,
    .cmd_addr, .cmd_data, .cmd_secret, .rsp_valid, .rsp_err, .rsp_data, .rsp_unprotected, .mode_state,
    .flash_addr, .flash_dq_o, .flash_dq_i, .flash_dq_oe_n, .flash_ce_n, .flash_we_n, .flash_oe_n,
    .accelerate_pin);
  fbd_flash_model fbd_flash_model_i (.clk_sys, .flash_addr, .flash_dq_o, .flash_dq_oe_n, .flash_ce_n,
    .flash_we_n, .flash_oe_n, .flash_dq_i);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // one request held until taken, then wait for its answer
  task automatic run(input fbd_op_e o, input logic [22:0] a, input logic [7:0] d);
    int n;
    n = 0;
    accel_hi = 1'b0;
    @(negedge clk_sys);
    cmd_op = o;
    cmd_addr = a;
    cmd_data = d;
    cmd_valid = 1'b1;
    // ready settles before the edge that takes the request
    while (cmd_ready !== 1'b1)
      @(negedge clk_sys);
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 400)
    begin
      @(negedge clk_sys);
      accel_hi = accel_hi | accelerate_pin;
      n++;
    end
    // an answer that never comes is a mismatch
    if (n == 400)
      err_count++;
    got_err = rsp_err;
  endtask
  task automatic e(input logic [22:0] a, input logic [7:0] d);
    exq.push_back({a, d});
  endtask
  task automatic ul();
    e(23'h000aaa, 8'haa);
    e(23'h000555, 8'h55);
  endtask
  // compare logged write cycles against expectation, then clear both
  task automatic cmp_log();
    chk(fbd_flash_model_i.wlog.size(), exq.size());
    foreach (exq[i])
      if (i < fbd_flash_model_i.wlog.size())
        chk(fbd_flash_model_i.wlog[i], exq[i]);
    fbd_flash_model_i.wlog.delete();
    exq.delete();
  endtask
  task automatic enter(input fbd_op_e o, input logic [7:0] b);
    run(o, 23'h000000, 8'h00);
    ul();
    e(23'h000aaa, b);
    cmp_log();
  endtask
  task automatic leave();
    run(OP_MODE_EXIT, 23'h000000, 8'h00);
    e(23'h000000, 8'h90);
    e(23'h000000, 8'h00);
    cmp_log();
    chk(mode_state, MODE_ARRAY);
    chk(accel_hi, 1'b0);
  endtask
  // plain read straight after reset, no prefix cycles
  task automatic t_read();
    chk({flash_ce_n, flash_we_n, flash_oe_n, accelerate_pin, mode_state}, 7'h70);
    run(OP_READ, 23'h012345, 8'h00);
    chk(rsp_data, 8'h79);
    cmp_log();
  endtask
  // mode-only orders turned away while in array mode
  task automatic t_refuse();
    fbd_op_e rl[9] = '{OP_PW_PROGRAM, OP_PW_READ, OP_PW_UNLOCK, OP_GUARD_PROGRAM, OP_PERS_ERASE_ALL,
      OP_LOCK_SET, OP_STATUS_READ, OP_BYPASS_PROGRAM, OP_MODE_EXIT};
    foreach (rl[i])
    begin
      run(rl[i], 23'h000001, 8'h01);
      chk(got_err, 1'b1);
    end
    cmp_log();
  endtask
  task automatic t_id();
    enter(OP_ID_ENTER, 8'h90);
    run(OP_READ, 23'h000006, 8'h00);
    chk(rsp_data, 8'h3a);
    leave();
  endtask
  task automatic t_pw();
    enter(OP_PW_ENTER, 8'h60);
    run(OP_PW_PROGRAM, 23'h000005, 8'h77);
    e(23'h000000, 8'ha0);
    e(23'h000005, 8'h77);
    cmp_log();
    run(OP_PW_READ, 23'h7ffff3, 8'h00);
    chk(rsp_data, 8'h3f);
    run(OP_PW_UNLOCK, 23'h000000, 8'h00);
    e(23'h000000, 8'h25);
    e(23'h000000, 8'h03);
    for (int k = 0; k < 8; k++)
      e(23'(k), cmd_secret[8*k +: 8]);
    e(23'h000000, 8'h29);
    cmp_log();
    leave();
  endtask
  // dynamic and persistent guards, status bit, lock freeze
  task automatic t_guard();
    enter(OP_DYN_ENTER, 8'he0);
    run(OP_GUARD_PROGRAM, 23'h012345, 8'h01);
    e(23'h000000, 8'ha0);
    e(23'h012345, 8'h01);
    cmp_log();
    chk(accel_hi, 1'b1);
    run(OP_STATUS_READ, 23'h012345, 8'h00);
    chk(rsp_unprotected, 1'b1);
    run(OP_STATUS_READ, 23'h012344, 8'h00);
    chk(rsp_unprotected, 1'b0);
    run(OP_PERS_ERASE_ALL, 23'h000000, 8'h00);
    chk(got_err, 1'b1);
    leave();
    enter(OP_PERS_ENTER, 8'hc0);
    // persistent guard ignores the data byte and always writes zero
    run(OP_GUARD_PROGRAM, 23'h020000, 8'h01);
    e(23'h000000, 8'ha0);
    e(23'h020000, 8'h00);
    cmp_log();
    chk(accel_hi, 1'b1);
    run(OP_PERS_ERASE_ALL, 23'h000000, 8'h00);
    e(23'h000000, 8'h80);
    e(23'h000000, 8'h30);
    cmp_log();
    leave();
    enter(OP_LOCK_ENTER, 8'h50);
    run(OP_LOCK_SET, 23'h000000, 8'h00);
    e(23'h000000, 8'ha0);
    e(23'h000000, 8'h00);
    cmp_log();
    run(OP_STATUS_READ, 23'h000001, 8'h00);
    chk(rsp_unprotected, 1'b1);
    leave();
  endtask
  // clock enable low: a request waits and nothing moves
  task automatic t_ce();
    @(negedge clk_sys);
    ce_sys = 1'b0;
    cmd_op = OP_RESET;
    cmd_valid = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk({cmd_ready, flash_ce_n, rsp_valid}, 3'b010);
    cmd_valid = 1'b0;
    ce_sys = 1'b1;
  endtask
  task automatic t_erase();
    run(OP_CHIP_ERASE, 23'h000000, 8'h00);
    ul();
    e(23'h000aaa, 8'h80);
    ul();
    e(23'h000aaa, 8'h10);
    cmp_log();
    run(OP_SECTOR_ERASE, 23'h034567, 8'h00);
    ul();
    e(23'h000aaa, 8'h80);
    ul();
    e(23'h034567, 8'h30);
    cmp_log();
    run(OP_SUSPEND, 23'h000000, 8'h00);
    e(23'h000000, 8'hb0);
    cmp_log();
    run(OP_RESUME, 23'h000000, 8'h00);
    e(23'h000000, 8'h30);
    cmp_log();
  endtask
  task automatic t_buf();
    run(OP_BUF_START, 23'h040000, 8'h01);
    ul();
    e(23'h040000, 8'h25);
    e(23'h040000, 8'h01);
    run(OP_BUF_LOAD, 23'h040010, 8'h5a);
    run(OP_BUF_LOAD, 23'h040011, 8'ha5);
    e(23'h040010, 8'h5a);
    e(23'h040011, 8'ha5);
    cmp_log();
    run(OP_BUF_COMMIT, 23'h040000, 8'h00);
    e(23'h040000, 8'h29);
    cmp_log();
    run(OP_BUF_ABORT, 23'h000000, 8'h00);
    ul();
    e(23'h000aaa, 8'hf0);
    cmp_log();
    run(OP_RESET, 23'h000000, 8'h00);
    e(23'h000000, 8'hf0);
    cmp_log();
  endtask
  task automatic t_modes();
    enter(OP_SECURE_ENTER, 8'h88);
    run(OP_SECURE_EXIT, 23'h000000, 8'h00);
    ul();
    e(23'h000aaa, 8'h90);
    e(23'h000000, 8'h00);
    cmp_log();
    enter(OP_BYPASS_ENTER, 8'h20);
    run(OP_BYPASS_PROGRAM, 23'h050505, 8'h3c);
    e(23'h000000, 8'ha0);
    e(23'h050505, 8'h3c);
    cmp_log();
    leave();
    run(OP_PROGRAM, 23'h060606, 8'hc3);
    ul();
    e(23'h000aaa, 8'ha0);
    e(23'h060606, 8'hc3);
    cmp_log();
  endtask
  // main sequence after a 16-clock reset
  initial
  begin
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys);
    resetn = 1'b1;
    t_read();
    t_refuse();
    t_id();
    t_pw();
    t_guard();
    t_ce();
    t_erase();
    t_buf();
    t_modes();
    print_verdict();
  end
  // hang guard, well above the under 1500 clocks the run needs
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      print_verdict();
    end
  end
endmodule

// ### bench/fbd_flash_model.sv
// byte-wide flash stand-in: logs write cycles, answers read cycles
// assumes pins move on clk_sys edges as the controller drives them
`timescale 1ns/10ps
module fbd_flash_model
  import fbd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic [7:0] flash_dq_o,
  input wire logic flash_dq_oe_n,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n,
  output logic [7:0] flash_dq_i
);
  logic we_q = 1'b1; // strobe level one clock ago
  logic [7:0] dq_r = 8'h00; // read data driven back
  logic [30:0] wlog[$]; // address and data of each write, in order
  assign flash_dq_i = dq_r;
  // latch on the strobe's rising edge; any order, any bits accepted
  always @(posedge clk_sys)
  begin
    we_q <= flash_we_n;
    if (flash_we_n && !we_q && !flash_ce_n && !flash_dq_oe_n)
    begin
      wlog.push_back({flash_addr, flash_dq_o});
    end
  end
  // data from the low address byte; bit0 doubles as guard status, 1 = open
  always @(posedge clk_sys)
  begin
    if (!flash_ce_n && !flash_oe_n)
    begin
      dq_r <= flash_addr[7:0] ^ 8'h3c;
    end
    else
    begin
      dq_r <= ~dq_r; // released bus flips every bit of the last byte each clock
    end
  end
endmodule

// ### inc/fbd_pkg.sv
// constants, operation codes and mode names for the flash command sequencer
// assumes one 125 MHz clock and a byte-wide parallel flash on the far side
//
// What this block does
// R1: fields the device ignores are driven as zero
// R2: reset command returns device to array reading
// R3: array read is one plain read cycle
// R4: mode instructions only after that mode's entry
// R5: leave entered modes with 90 then 00
// R6: low address bits pick password portion
// R7: full two-cycle program for every password portion
// R8: password reads drive the whole address bus; code drives a[2:0] with the upper bits zero
// R9: unlock sends every password part in full
// R10: data line zero high means unprotected
// R11: accelerate pin high while setting guard bits
// R12: erase-all guards: device pre-programs, host just waits
// R13: any address inside sector serves as locator
// R14: identification entry AA, 55, 90 prefix
// R15: secure region entry 88, exit 90 00
// R16: buffer load: 25, count minus one, pairs
// R17: write 29 to sector starts buffer programming
// R18: abort reset is AA, 55, F0
// R19: one suspend write pauses program or erase
// R20: one write of 30 resumes
// R21: erase is six writes, 10 chip, 30 sector
// R22: bypass: 20 entry, A0 plus pair, 90 00 exit
package fbd_pkg;
  localparam int ADDR_W = 23; // byte address, lowest line included
  localparam int CLK_MHZ = 125;
  // bus timing, least times in ns (plain defaults)
  localparam int T_ADDR_SETUP_NS = 20;
  localparam int T_WRITE_PULSE_NS = 35;
  localparam int T_READ_ACCESS_NS = 70;
  localparam int T_RECOVER_NS = 30;
  // least times round up to whole cycles, never below one
  localparam int CYC_ADDR_SETUP = (T_ADDR_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_WRITE_PULSE = (T_WRITE_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_READ_ACCESS = (T_READ_ACCESS_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_RECOVER = (T_RECOVER_NS * CLK_MHZ + 999) / 1000;
  // unlock addresses in byte mode
  localparam logic [22:0] ADDR_UNLOCK1 = 23'h000aaa;
  localparam logic [22:0] ADDR_UNLOCK2 = 23'h000555;
  localparam logic [22:0] ADDR_ZERO = 23'h000000;
  // command bytes
  localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_RESET = 8'hf0;
  localparam logic [7:0] CMD_ID = 8'h90;
  localparam logic [7:0] CMD_EXIT2 = 8'h00;
  localparam logic [7:0] CMD_SECURE = 8'h88;
  localparam logic [7:0] CMD_PROGRAM = 8'ha0;
  localparam logic [7:0] CMD_BUF_LOAD = 8'h25;
  localparam logic [7:0] CMD_BUF_COMMIT = 8'h29;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CMD_BYPASS = 8'h20;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [7:0] CMD_PW_ENTRY = 8'h60;
  localparam logic [7:0] CMD_PERS_ENTRY = 8'hc0;
  localparam logic [7:0] CMD_LOCK_ENTRY = 8'h50;
  localparam logic [7:0] CMD_DYN_ENTRY = 8'he0;
  localparam logic [7:0] PW_PART_COUNT = 8'h03; // second unlock byte
  localparam logic [3:0] PW_UNLOCK_LAST = 4'ha; // 11 cycles, index 0..10
  // user operations
  typedef enum logic [4:0] {
    OP_READ, OP_RESET, OP_ID_ENTER, OP_SECURE_ENTER, OP_SECURE_EXIT,
    OP_PROGRAM, OP_BUF_START, OP_BUF_LOAD, OP_BUF_COMMIT, OP_BUF_ABORT,
    OP_CHIP_ERASE, OP_SECTOR_ERASE, OP_BYPASS_ENTER, OP_BYPASS_PROGRAM,
    OP_MODE_EXIT, OP_SUSPEND, OP_RESUME, OP_PW_ENTER, OP_PERS_ENTER,
    OP_LOCK_ENTER, OP_DYN_ENTER, OP_PW_PROGRAM, OP_PW_READ, OP_PW_UNLOCK,
    OP_GUARD_PROGRAM, OP_PERS_ERASE_ALL, OP_LOCK_SET, OP_STATUS_READ
  } fbd_op_e;
  // command set the device is believed to be in
  typedef enum logic [2:0] {
    MODE_ARRAY, MODE_ID, MODE_SECURE, MODE_BYPASS,
    MODE_PW, MODE_PERS, MODE_LOCK, MODE_DYN
  } fbd_mode_e;
endpackage

// ### src/fbd_bus_cycle.sv
// one asynchronous flash bus cycle: address setup, strobe, recovery
// assumes the flash pins are sampled synchronously to clk_sys
`timescale 1ns/10ps
module fbd_bus_cycle
  import fbd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ce_sys,
  input wire logic start,
  input wire logic is_read,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  output logic done,
  output logic [7:0] rdata,
  output logic [ADDR_W-1:0] flash_addr,
  output logic [7:0] flash_dq_o,
  input wire logic [7:0] flash_dq_i,
  output logic flash_dq_oe_n,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n
);
  typedef enum logic [1:0] {PH_IDLE, PH_SETUP, PH_STROBE, PH_RECOVER} fbd_phase_e;
  fbd_phase_e phase_r; // cycle phase
  logic [3:0] cnt_r; // cycles left in phase after this one
  logic rd_r; // current cycle is a read

  // phase sequencer with cycle counts per phase
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      phase_r <= PH_IDLE;
      cnt_r <= 4'h0;
      rd_r <= 1'b0;
    end
    else if (ce_sys)
    begin
      unique case (phase_r)
        PH_IDLE:
          if (start)
          begin
            phase_r <= PH_SETUP;
            rd_r <= is_read;
            cnt_r <= 4'(CYC_ADDR_SETUP - 1);
          end
        PH_SETUP:
          if (cnt_r == 4'h0)
          begin
            phase_r <= PH_STROBE;
            // reads need the longer access window
            cnt_r <= rd_r ? 4'(CYC_READ_ACCESS - 1) : 4'(CYC_WRITE_PULSE - 1);
          end
          else
            cnt_r <= cnt_r - 4'h1;
        PH_STROBE:
          if (cnt_r == 4'h0)
          begin
            phase_r <= PH_RECOVER;
            cnt_r <= 4'(CYC_RECOVER - 1);
          end
          else
            cnt_r <= cnt_r - 4'h1;
        PH_RECOVER:
          if (cnt_r == 4'h0)
            phase_r <= PH_IDLE;
          else
            cnt_r <= cnt_r - 4'h1;
      endcase
    end
  end

  // pin drive; address and data held stable for the whole cycle
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      flash_addr <= 23'h000000;
      flash_dq_o <= 8'h00;
      flash_dq_oe_n <= 1'b1;
      flash_ce_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_oe_n <= 1'b1;
    end
    else if (ce_sys)
    begin
      if (phase_r == PH_IDLE && start)
      begin
        flash_addr <= addr;
        flash_dq_o <= wdata;
        flash_dq_oe_n <= is_read; // low while we drive the data lines
        flash_ce_n <= 1'b0;
      end
      else if (phase_r == PH_SETUP && cnt_r == 4'h0)
      begin
        flash_we_n <= rd_r;
        flash_oe_n <= !rd_r;
      end
      else if (phase_r == PH_STROBE && cnt_r == 4'h0)
      begin
        // rising write strobe latches the data while still driven
        flash_we_n <= 1'b1;
        flash_oe_n <= 1'b1;
      end
      else if (phase_r == PH_RECOVER && cnt_r == 4'h0)
      begin
        flash_ce_n <= 1'b1;
        flash_dq_oe_n <= 1'b1;
      end
    end
  end

  // read data sampled at end of access window
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      rdata <= 8'h00;
    else if (ce_sys && phase_r == PH_STROBE && cnt_r == 4'h0 && rd_r)
      rdata <= flash_dq_i;
  end

  // done pulses on the last recovery cycle
  assign done = ce_sys && phase_r == PH_RECOVER && cnt_r == 4'h0;
endmodule

// ### src/fbd_controller.sv
// host-side command sequencer for a byte-wide parallel flash
// assumes the user holds cmd_* stable only while cmd_valid and cmd_ready meet
`timescale 1ns/10ps
module fbd_controller
  import fbd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ce_sys,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire fbd_op_e cmd_op,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [7:0] cmd_data,
  input wire logic [63:0] cmd_secret,
  output logic rsp_valid,
  output logic rsp_err,
  output logic [7:0] rsp_data,
  output logic rsp_unprotected,
  output fbd_mode_e mode_state,
  output logic [ADDR_W-1:0] flash_addr,
  output logic [7:0] flash_dq_o,
  input wire logic [7:0] flash_dq_i,
  output logic flash_dq_oe_n,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic accelerate_pin
);
  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT} fbd_state_e;
  fbd_state_e state_r; // sequencer state
  fbd_op_e op_r; // operation in progress
  fbd_mode_e mode_r; // command set the device is in
  logic [ADDR_W-1:0] addr_r; // user address
  logic [7:0] data_r; // user data
  logic [63:0] secret_r; // password for unlock
  logic [3:0] idx_r; // bus cycle index in sequence
  logic [32:0] step; // {read, last, address, data}
  logic bus_start; // launch one bus cycle
  logic bus_done; // bus cycle finished
  logic [7:0] bus_rdata; // byte read back

  // true when the op may be sent in the current mode
  function automatic logic op_allowed(fbd_op_e op, fbd_mode_e m);
    logic ok;
    ok = 1'b1;
    unique case (op)
      OP_PW_PROGRAM, OP_PW_READ, OP_PW_UNLOCK: ok = (m == MODE_PW); // R4
      OP_GUARD_PROGRAM: ok = (m == MODE_PERS) || (m == MODE_DYN); // R4
      OP_PERS_ERASE_ALL: ok = (m == MODE_PERS); // R4
      OP_LOCK_SET: ok = (m == MODE_LOCK); // R4
      OP_STATUS_READ: ok = (m == MODE_PERS) || (m == MODE_DYN) || (m == MODE_LOCK); // R4
      OP_BYPASS_PROGRAM: ok = (m == MODE_BYPASS); // R22
      OP_MODE_EXIT: ok = (m != MODE_ARRAY);
      default: ok = 1'b1;
    endcase
    return ok;
  endfunction

  // one bus cycle of a sequence; unlock prefix is the default
  function automatic logic [32:0] seq_step(fbd_op_e op, logic [3:0] i, logic [ADDR_W-1:0] a,
                                           logic [7:0] d, logic [63:0] pw, fbd_mode_e m);
    logic rd;
    logic last;
    logic [ADDR_W-1:0] ad;
    logic [7:0] dt;
    logic [2:0] k;
    rd = 1'b0;
    last = 1'b0;
    k = 3'(i - 4'h2);
    ad = (i == 4'h1) ? ADDR_UNLOCK2 : ADDR_UNLOCK1; // R14
    dt = (i == 4'h1) ? CMD_UNLOCK2 : CMD_UNLOCK1;
    unique case (op)
      OP_READ:
      begin
        rd = 1'b1; // R3
        last = 1'b1;
        ad = a;
      end
      OP_RESET:
      begin
        last = 1'b1; // R2
        ad = ADDR_ZERO; // R1
        dt = CMD_RESET;
      end
      OP_ID_ENTER: if (i == 4'h2) begin last = 1'b1; dt = CMD_ID; end // R14
      OP_SECURE_ENTER: if (i == 4'h2) begin last = 1'b1; dt = CMD_SECURE; end // R15
      OP_SECURE_EXIT: // R15
        if (i == 4'h2) dt = CMD_ID;
        else if (i == 4'h3) begin last = 1'b1; ad = ADDR_ZERO; dt = CMD_EXIT2; end
      OP_PROGRAM:
        if (i == 4'h2) dt = CMD_PROGRAM;
        else if (i == 4'h3) begin last = 1'b1; ad = a; dt = d; end
      OP_BUF_START: // R16
        if (i == 4'h2) begin ad = a; dt = CMD_BUF_LOAD; end // R13
        else if (i == 4'h3) begin last = 1'b1; ad = a; dt = d; end
      OP_BUF_LOAD: begin last = 1'b1; ad = a; dt = d; end // R16
      OP_BUF_COMMIT: begin last = 1'b1; ad = a; dt = CMD_BUF_COMMIT; end // R17
      OP_BUF_ABORT: if (i == 4'h2) begin last = 1'b1; dt = CMD_RESET; end // R18
      OP_CHIP_ERASE, OP_SECTOR_ERASE: // R21
        if (i == 4'h2) dt = CMD_ERASE_SETUP;
        else if (i == 4'h3) dt = CMD_UNLOCK1;
        else if (i == 4'h4) begin ad = ADDR_UNLOCK2; dt = CMD_UNLOCK2; end
        else if (i == 4'h5)
        begin
          last = 1'b1;
          ad = (op == OP_CHIP_ERASE) ? ADDR_UNLOCK1 : a; // R13
          dt = (op == OP_CHIP_ERASE) ? CMD_CHIP_ERASE : CMD_SECTOR_ERASE;
        end
      OP_BYPASS_ENTER: if (i == 4'h2) begin last = 1'b1; dt = CMD_BYPASS; end // R22
      OP_BYPASS_PROGRAM, OP_GUARD_PROGRAM, OP_LOCK_SET, OP_PW_PROGRAM:
        if (i == 4'h0) begin ad = ADDR_ZERO; dt = CMD_PROGRAM; end // R22
        else
        begin
          last = 1'b1;
          ad = (op == OP_LOCK_SET) ? ADDR_ZERO : a; // R6 R13
          dt = d;
          // dynamic guard takes set/clear on bit 0; persistent guard and lock set write 00
          if (op == OP_GUARD_PROGRAM) dt = (m == MODE_DYN) ? {7'h00, d[0]} : 8'h00;
          if (op == OP_LOCK_SET) dt = 8'h00;
        end
      OP_MODE_EXIT: // R5
        if (i == 4'h0) begin ad = ADDR_ZERO; dt = CMD_ID; end
        else begin last = 1'b1; ad = ADDR_ZERO; dt = CMD_EXIT2; end
      OP_SUSPEND: begin last = 1'b1; ad = ADDR_ZERO; dt = CMD_SUSPEND; end // R19
      OP_RESUME: begin last = 1'b1; ad = ADDR_ZERO; dt = CMD_RESUME; end // R20
      OP_PW_ENTER: if (i == 4'h2) begin last = 1'b1; dt = CMD_PW_ENTRY; end // R4
      OP_PERS_ENTER: if (i == 4'h2) begin last = 1'b1; dt = CMD_PERS_ENTRY; end // R4
      OP_LOCK_ENTER: if (i == 4'h2) begin last = 1'b1; dt = CMD_LOCK_ENTRY; end // R4
      OP_DYN_ENTER: if (i == 4'h2) begin last = 1'b1; dt = CMD_DYN_ENTRY; end // R4
      OP_PW_READ:
      begin
        rd = 1'b1;
        last = 1'b1;
        ad = {20'h00000, a[2:0]}; // R8
      end
      OP_PW_UNLOCK: // R9
      begin
        ad = ADDR_ZERO;
        if (i == 4'h0) dt = CMD_BUF_LOAD;
        else if (i == 4'h1) dt = PW_PART_COUNT;
        else if (i == PW_UNLOCK_LAST) begin last = 1'b1; dt = CMD_BUF_COMMIT; end
        else begin ad = {20'h00000, k}; dt = pw[{k, 3'b000} +: 8]; end
      end
      OP_PERS_ERASE_ALL: // R12
        if (i == 4'h0) begin ad = ADDR_ZERO; dt = CMD_ERASE_SETUP; end
        else begin last = 1'b1; ad = ADDR_ZERO; dt = CMD_SECTOR_ERASE; end
      OP_STATUS_READ:
      begin
        rd = 1'b1;
        last = 1'b1;
        ad = a; // R13
      end
    endcase
    return {rd, last, ad, dt};
  endfunction

  assign step = seq_step(op_r, idx_r, addr_r, data_r, secret_r, mode_r);
  assign cmd_ready = (state_r == ST_IDLE) && ce_sys;
  assign bus_start = ce_sys && (state_r == ST_ISSUE);
  assign mode_state = mode_r;

  // sequencer: accept, issue cycles one by one, finish
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      state_r <= ST_IDLE;
      op_r <= OP_READ;
      addr_r <= 23'h000000;
      data_r <= 8'h00;
      secret_r <= 64'h0000000000000000;
      idx_r <= 4'h0;
    end
    else if (ce_sys)
    begin
      unique case (state_r)
        ST_IDLE:
          // refused ops never reach the pins
          if (cmd_valid && op_allowed(cmd_op, mode_r))
          begin
            state_r <= ST_ISSUE;
            op_r <= cmd_op;
            addr_r <= cmd_addr;
            data_r <= cmd_data;
            secret_r <= cmd_secret;
            idx_r <= 4'h0;
          end
        ST_ISSUE: state_r <= ST_WAIT;
        ST_WAIT:
          if (bus_done)
          begin
            state_r <= step[31] ? ST_IDLE : ST_ISSUE;
            idx_r <= idx_r + 4'h1;
          end
      endcase
    end
  end

  // mode tracking, updated when a sequence completes
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      mode_r <= MODE_ARRAY;
    else if (ce_sys && state_r == ST_WAIT && bus_done && step[31])
    begin
      unique case (op_r)
        OP_ID_ENTER: mode_r <= MODE_ID; // R14
        OP_SECURE_ENTER: mode_r <= MODE_SECURE; // R15
        OP_BYPASS_ENTER: mode_r <= MODE_BYPASS; // R22
        OP_PW_ENTER: mode_r <= MODE_PW;
        OP_PERS_ENTER: mode_r <= MODE_PERS;
        OP_LOCK_ENTER: mode_r <= MODE_LOCK;
        OP_DYN_ENTER: mode_r <= MODE_DYN;
        OP_MODE_EXIT, OP_SECURE_EXIT, OP_RESET, OP_BUF_ABORT: mode_r <= MODE_ARRAY; // R2 R5
        default: mode_r <= mode_r;
      endcase
    end
  end

  // accelerate pin high across guard-setting sequences
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      accelerate_pin <= 1'b0;
    else if (ce_sys && state_r == ST_IDLE)
      accelerate_pin <= cmd_valid && cmd_op == OP_GUARD_PROGRAM && op_allowed(cmd_op, mode_r); // R11
    else if (ce_sys && state_r == ST_WAIT && bus_done && step[31])
      accelerate_pin <= 1'b0;
  end

  // answer: completion or refusal pulse, read data held
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      rsp_valid <= 1'b0;
      rsp_err <= 1'b0;
      rsp_data <= 8'h00;
      rsp_unprotected <= 1'b0;
    end
    else if (ce_sys)
    begin
      rsp_valid <= (state_r == ST_WAIT && bus_done && step[31]) ||
                   (state_r == ST_IDLE && cmd_valid && !op_allowed(cmd_op, mode_r));
      rsp_err <= state_r == ST_IDLE && cmd_valid && !op_allowed(cmd_op, mode_r);
      if (state_r == ST_WAIT && bus_done && step[32])
      begin
        rsp_data <= bus_rdata;
        rsp_unprotected <= bus_rdata[0]; // R10
      end
    end
  end

  fbd_bus_cycle u_bus (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .ce_sys(ce_sys),
    .start(bus_start),
    .is_read(step[32]),
    .addr(step[30:8]),
    .wdata(step[7:0]),
    .done(bus_done),
    .rdata(bus_rdata),
    .flash_addr(flash_addr),
    .flash_dq_o(flash_dq_o),
    .flash_dq_i(flash_dq_i),
    .flash_dq_oe_n(flash_dq_oe_n),
    .flash_ce_n(flash_ce_n),
    .flash_we_n(flash_we_n),
    .flash_oe_n(flash_oe_n)
  );
endmodule
